// ---- hdl/mwm_monitor.sv ----
// motion window monitor: following error, target reached, torque objects
// Behaviour
// - set status bit 13 when following error exceeds window beyond the timeout
// - following-error timeout is unsigned 16-bit ms, reset 0x0064
// - configurable following-error reaction; when set, log an error-history entry
// - set status bit 10 when position stays inside window beyond window time
// - all-ones position window switches position monitoring off; reset 0x0000000A
// - position window symmetric about target; only profile and interpolated position
// - position window time is unsigned 16-bit ms, reset 0x0064
// - velocity demand is read-only signed 32-bit ramp output and speed setpoint
// - set status bit 10 when speed stays inside velocity window beyond its time
// - velocity window unsigned 16-bit, symmetric, profile velocity, reset 0x001E
// - velocity window time unsigned 16-bit ms, reset zero
// - actual speed is read-only signed 32-bit value
// - target torque signed 16-bit read/write, reset zero, torque modes
// - torque scaled in thousandths of rated torque, 1000 means 100 percent
// - applied torque never exceeds peak torque even if host asks more
// - max torque limit unsigned 16-bit, reset zero, both torque modes
// - mode codes: PP 1, PV 3, PT 4, IP 7, CST 10
// - following-error window unsigned 32-bit, reset 0x100; all ones disables
`timescale 1ns/1ps
`default_nettype none
`include "mwm_params.svh"

module mwm_monitor
  import mwm_pkg::*;
#(
  parameter int unsigned TICK_CYC = `MWM_TICK_CYC,
  parameter logic [15:0] PEAK_TORQUE = 16'h0BB8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_idx_i,
  input wire logic [31:0] obj_wdata_i,
  output logic [31:0] obj_rdata_o,
  output logic obj_hit_o,
  input wire logic signed [7:0] mode_i,
  input wire logic signed [31:0] pos_demand_i,
  input wire logic signed [31:0] pos_actual_i,
  input wire logic signed [31:0] pos_target_i,
  input wire logic signed [31:0] vel_demand_i,
  input wire logic signed [31:0] vel_actual_i,
  output logic [15:0] status_o,
  output logic signed [31:0] vel_demand_o,
  output logic signed [15:0] torque_cmd_o,
  output logic [15:0] fe_reaction_o,
  output logic err_log_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [32:0] absdiff(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    absdiff = d[32] ? 33'(-d) : d;
  endfunction

  function automatic logic mode_is(input mwm_mode_t m, input mwm_mode_t a, input mwm_mode_t b);
    mode_is = (m == a) || (m == b);
  endfunction

  // ----------------------------------------------------------------
  // parameter objects
  // ----------------------------------------------------------------
  logic [15:0] fe_timeout_q;
  logic [31:0] fe_win_q;
  logic [15:0] fe_reaction_q;
  logic [31:0] pos_win_q;
  logic [15:0] pos_win_time_q;
  logic [15:0] vel_win_q;
  logic [15:0] vel_win_time_q;
  logic signed [15:0] trq_target_q;
  logic [15:0] trq_limit_q;
  logic signed [31:0] vel_actual_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_timeout_q <= `MWM_RST_FE_TIMEOUT;
      fe_win_q <= `MWM_RST_FE_WIN;
      fe_reaction_q <= `MWM_RST_FE_REACTION;
      pos_win_q <= `MWM_RST_POS_WIN;
      pos_win_time_q <= `MWM_RST_POS_WIN_TIME;
      vel_win_q <= `MWM_RST_VEL_WIN;
      vel_win_time_q <= `MWM_RST_VEL_WIN_TIME;
      trq_target_q <= `MWM_RST_TRQ_TARGET;
      trq_limit_q <= `MWM_RST_TRQ_LIMIT;
    end else if (obj_wr_i) begin
      unique case (obj_idx_i)
        `MWM_IDX_FE_TIMEOUT: fe_timeout_q <= obj_wdata_i[15:0];
        `MWM_IDX_FE_WIN: fe_win_q <= obj_wdata_i;
        `MWM_IDX_FE_REACTION: fe_reaction_q <= obj_wdata_i[15:0];
        `MWM_IDX_POS_WIN: pos_win_q <= obj_wdata_i;
        `MWM_IDX_POS_WIN_TIME: pos_win_time_q <= obj_wdata_i[15:0];
        `MWM_IDX_VEL_WIN: vel_win_q <= obj_wdata_i[15:0];
        `MWM_IDX_VEL_WIN_TIME: vel_win_time_q <= obj_wdata_i[15:0];
        `MWM_IDX_TRQ_TARGET: trq_target_q <= obj_wdata_i[15:0];
        `MWM_IDX_TRQ_LIMIT: trq_limit_q <= obj_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path, read-only measured values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vel_demand_o <= '0;
      vel_actual_q <= '0;
    end else begin
      vel_demand_o <= vel_demand_i;
      vel_actual_q <= vel_actual_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obj_rdata_o <= '0;
      obj_hit_o <= 1'b0;
    end else begin
      obj_hit_o <= 1'b1;
      unique case (obj_idx_i)
        `MWM_IDX_FE_TIMEOUT: obj_rdata_o <= {16'h0000, fe_timeout_q};
        `MWM_IDX_FE_WIN: obj_rdata_o <= fe_win_q;
        `MWM_IDX_FE_REACTION: obj_rdata_o <= {16'h0000, fe_reaction_q};
        `MWM_IDX_POS_WIN: obj_rdata_o <= pos_win_q;
        `MWM_IDX_POS_WIN_TIME: obj_rdata_o <= {16'h0000, pos_win_time_q};
        `MWM_IDX_VEL_DEMAND: obj_rdata_o <= vel_demand_o;
        `MWM_IDX_VEL_ACTUAL: obj_rdata_o <= vel_actual_q;
        `MWM_IDX_VEL_WIN: obj_rdata_o <= {16'h0000, vel_win_q};
        `MWM_IDX_VEL_WIN_TIME: obj_rdata_o <= {16'h0000, vel_win_time_q};
        `MWM_IDX_TRQ_TARGET: obj_rdata_o <= {{16{trq_target_q[15]}}, trq_target_q};
        `MWM_IDX_TRQ_LIMIT: obj_rdata_o <= {16'h0000, trq_limit_q};
        default: begin
          obj_rdata_o <= '0;
          obj_hit_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // window conditions
  // ----------------------------------------------------------------
  logic fe_cond, pos_cond, vel_cond;
  logic pos_mode, vel_mode;

  always_comb begin
    pos_mode = mode_is(mode_i, `MWM_MODE_PP, `MWM_MODE_IP);
    vel_mode = (mode_i == `MWM_MODE_PV);
    // strictly above the window, and the all-ones code disables the check
    fe_cond = (fe_win_q != `MWM_WIN_OFF)
              && (absdiff(pos_actual_i, pos_demand_i) > {1'b0, fe_win_q});
    pos_cond = pos_mode && (pos_win_q != `MWM_WIN_OFF)
               && (absdiff(pos_actual_i, pos_target_i) < {1'b0, pos_win_q});
    vel_cond = vel_mode && (absdiff(vel_actual_i, vel_demand_i) < {17'h00000, vel_win_q});
  end

  // ----------------------------------------------------------------
  // window timers: one per monitor, saturating ms count
  // ----------------------------------------------------------------
  logic [2:0] cond_w;
  logic [15:0] limit_w [3];
  logic [16:0] ms_q [3];
  logic [2:0] hit_q;

  assign cond_w = {vel_cond, pos_cond, fe_cond};
  assign limit_w[0] = fe_timeout_q;
  assign limit_w[1] = pos_win_time_q;
  assign limit_w[2] = vel_win_time_q;

  for (genvar g = 0; g < 3; g++) begin : g_win
    always_ff @(posedge clk_i) begin
      if (rst_i || !cond_w[g]) begin
        ms_q[g] <= '0;
        hit_q[g] <= 1'b0;
      end else begin
        if (tick_q && ms_q[g] <= {1'b0, limit_w[g]}) begin
          ms_q[g] <= ms_q[g] + 17'h00001;
        end
        // "longer than" the time: one more ms than the limit
        hit_q[g] <= (ms_q[g] > {1'b0, limit_w[g]});
      end
    end
  end

  // ----------------------------------------------------------------
  // status, reaction and torque
  // ----------------------------------------------------------------
  logic fe_hit_d1_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      fe_hit_d1_q <= 1'b0;
      err_log_o <= 1'b0;
      fe_reaction_o <= '0;
    end else begin
      status_o <= '0;
      status_o[`MWM_STS_FOLLOW_BIT] <= hit_q[0];
      status_o[`MWM_STS_TARGET_BIT] <= hit_q[1] | hit_q[2];
      fe_hit_d1_q <= hit_q[0];
      // log once per new following error, only when a reaction is set
      err_log_o <= hit_q[0] && !fe_hit_d1_q && (fe_reaction_q != 16'h0000);
      fe_reaction_o <= hit_q[0] ? fe_reaction_q : 16'h0000;
    end
  end

  logic [15:0] trq_cap;
  logic signed [16:0] trq_lim_s;
  logic signed [16:0] trq_req;

  always_comb begin
    // limits share the thousandths scale, so they compare directly
    trq_cap = (trq_limit_q < PEAK_TORQUE) ? trq_limit_q : PEAK_TORQUE;
    trq_lim_s = $signed({1'b0, trq_cap});
    trq_req = 17'(trq_target_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      torque_cmd_o <= '0;
    end else if (mode_is(mode_i, `MWM_MODE_PT, `MWM_MODE_CST)) begin
      if (trq_req > trq_lim_s) begin
        torque_cmd_o <= trq_lim_s[15:0];
      end else if (trq_req < -trq_lim_s) begin
        torque_cmd_o <= 16'(-trq_lim_s);
      end else begin
        torque_cmd_o <= trq_target_q;
      end
    end else begin
      torque_cmd_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a monitor whose timer has passed its limit while its condition still holds
  sequence s_fe_due;
    fe_cond && (ms_q[0] > {1'b0, fe_timeout_q});
  endsequence

  sequence s_pos_due;
    pos_cond && (ms_q[1] > {1'b0, pos_win_time_q});
  endsequence

  sequence s_vel_due;
    vel_cond && (ms_q[2] > {1'b0, vel_win_time_q});
  endsequence

  // the hit register and then the status register each add one edge
  sequence s_follow_shown;
    ##2 status_o[`MWM_STS_FOLLOW_BIT];
  endsequence

  sequence s_target_shown;
    ##2 status_o[`MWM_STS_TARGET_BIT];
  endsequence

  sequence s_fe_new;
    hit_q[0] && !fe_hit_d1_q && (fe_reaction_q != 16'h0000);
  endsequence

  // following error, its reaction and its log pulse
  chk_fe_off: assert property (@(posedge clk_i) disable iff (rst_i)
    fe_win_q == `MWM_WIN_OFF |=> ##1 !status_o[`MWM_STS_FOLLOW_BIT]) else $error("fe flagged while off");
  chk_fe_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !fe_cond |-> ##2 !status_o[`MWM_STS_FOLLOW_BIT]) else $error("fe bit not cleared");
  chk_fe_tmo: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hit_q[0]) |-> ms_q[0] > {1'b0, fe_timeout_q}) else $error("fe before timeout");
  chk_fe_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fe_due |-> s_follow_shown) else $error("fe bit not set after timeout");
  chk_err_log: assert property (@(posedge clk_i) disable iff (rst_i)
    err_log_o |-> $past(fe_reaction_q) != 16'h0000 && $past(hit_q[0])) else $error("bad error log");
  chk_log_new: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fe_new |=> err_log_o) else $error("new following error not logged");
  chk_log_once: assert property (@(posedge clk_i) disable iff (rst_i)
    err_log_o |=> !err_log_o) else $error("error log longer than one cycle");
  chk_frx_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !hit_q[0] |=> fe_reaction_o == 16'h0000) else $error("reaction without following error");

  // target reached from the position and velocity windows
  chk_pos_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pos_mode && !vel_mode) [*2] |=> !status_o[`MWM_STS_TARGET_BIT]) else $error("target outside mode");
  chk_pos_off: assert property (@(posedge clk_i) disable iff (rst_i)
    pos_win_q == `MWM_WIN_OFF |=> !hit_q[1]) else $error("pos window off ignored");
  chk_pos_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pos_due |-> s_target_shown) else $error("position target not flagged");
  chk_vel_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_vel_due |-> s_target_shown) else $error("velocity target not flagged");
  chk_vel_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !vel_mode |=> !hit_q[2]) else $error("velocity hit outside its mode");
  chk_tgt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !pos_cond && !vel_cond |-> ##2 !status_o[`MWM_STS_TARGET_BIT]) else $error("target bit not cleared");
  chk_status_rest: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_o & 16'hDBFF) == 16'h0000) else $error("unused status bit set");

  // millisecond timers
  chk_ms_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    fe_cond && !tick_q |=> ms_q[0] == $past(ms_q[0])) else $error("timer moved without tick");
  chk_ms_step: assert property (@(posedge clk_i) disable iff (rst_i)
    fe_cond && tick_q && (ms_q[0] <= {1'b0, fe_timeout_q}) |=> ms_q[0] == $past(ms_q[0]) + 17'h00001)
    else $error("timer missed a tick");
  chk_ms_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !pos_cond |=> ms_q[1] == 17'h00000) else $error("timer not cleared");
  chk_tick_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_q |=> !tick_q) else $error("tick longer than one cycle");

  // torque and measured values
  chk_trq_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    $signed(torque_cmd_o) <= $signed({1'b0, PEAK_TORQUE})) else $error("torque above peak");
  chk_trq_lim: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> 17'(torque_cmd_o) <= $past(trq_lim_s)) else $error("torque above limit");
  chk_trq_neg: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> 17'(torque_cmd_o) >= -$past(trq_lim_s)) else $error("torque below negative limit");
  chk_trq_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_is(mode_i, `MWM_MODE_PT, `MWM_MODE_CST) |=> torque_cmd_o == 16'sh0000) else $error("torque outside mode");
  chk_vd_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 vel_demand_o == $past(vel_demand_i)) else $error("velocity demand stale");

endmodule
`default_nettype wire

// ---- hdl/mwm_params.svh ----
// object indices, reset values and timing constants of the motion window monitor
`ifndef MWM_PARAMS_SVH
`define MWM_PARAMS_SVH

`define MWM_IDX_FE_TIMEOUT 16'h6066
`define MWM_IDX_POS_WIN 16'h6067
`define MWM_IDX_POS_WIN_TIME 16'h6068
`define MWM_IDX_VEL_DEMAND 16'h606B
`define MWM_IDX_VEL_ACTUAL 16'h606C
`define MWM_IDX_VEL_WIN 16'h606D
`define MWM_IDX_VEL_WIN_TIME 16'h606E
`define MWM_IDX_TRQ_TARGET 16'h6071
`define MWM_IDX_TRQ_LIMIT 16'h6072
`define MWM_IDX_FE_WIN 16'h6065
`define MWM_IDX_FE_REACTION 16'h3700

`define MWM_RST_FE_TIMEOUT 16'h0064
`define MWM_RST_POS_WIN 32'h0000000A
`define MWM_RST_POS_WIN_TIME 16'h0064
`define MWM_RST_VEL_WIN 16'h001E
`define MWM_RST_VEL_WIN_TIME 16'h0000
`define MWM_RST_TRQ_TARGET 16'h0000
`define MWM_RST_TRQ_LIMIT 16'h0000
`define MWM_RST_FE_WIN 32'h00000100
`define MWM_RST_FE_REACTION 16'h0000
`define MWM_WIN_OFF 32'hFFFFFFFF

`define MWM_STS_TARGET_BIT 10
`define MWM_STS_FOLLOW_BIT 13

`define MWM_MODE_PP 8'sh01
`define MWM_MODE_PV 8'sh03
`define MWM_MODE_PT 8'sh04
`define MWM_MODE_IP 8'sh07
`define MWM_MODE_CST 8'sh0A

`define MWM_CLK_HZ 100000000
`define MWM_TICK_MS 1
`define MWM_TICK_CYC ((`MWM_CLK_HZ / 1000) * `MWM_TICK_MS)

`endif

// ---- hdl/mwm_pkg.sv ----
// types shared by the motion window monitor
package mwm_pkg;
  typedef logic [15:0] mwm_idx_t;
  typedef logic signed [7:0] mwm_mode_t;
  typedef enum logic [1:0] {
    MWM_OUT = 2'b00,
    MWM_WAIT = 2'b01,
    MWM_HIT = 2'b11
  } mwm_win_e;
endpackage

// ---- tb/motion_window_monitor_bench.sv ----
// self-checking bench for the motion window monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module motion_window_monitor_bench;
  logic clk, rst, wr, hit, elog, h, got;
  logic [15:0] idx, status, frx;
  logic [31:0] wd, rdat, d;
  logic signed [7:0] mode;
  logic signed [31:0] pdem, pact, ptgt, vdem, vact, vdo;
  logic signed [15:0] trq;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_log = 0;
  logic [15:0] ri [11] = '{16'h6066, 16'h6065, 16'h6067, 16'h6068, 16'h606B, 16'h606C, 16'h606D, 16'h606E,
    16'h6071, 16'h6072, 16'h3700};
  logic [31:0] rv [11] = '{32'h64, 32'h100, 32'hA, 32'h64, 32'h0, 32'h0, 32'h1E, 32'h0, 32'h0, 32'h0, 32'h0};
  mwm_monitor #(.TICK_CYC(10), .PEAK_TORQUE(16'h0BB8)) dut (.clk_i(clk), .rst_i(rst), .obj_wr_i(wr),
    .obj_idx_i(idx), .obj_wdata_i(wd), .obj_rdata_o(rdat), .obj_hit_o(hit), .mode_i(mode),
    .pos_demand_i(pdem), .pos_actual_i(pact), .pos_target_i(ptgt), .vel_demand_i(vdem),
    .vel_actual_i(vact), .status_o(status), .vel_demand_o(vdo), .torque_cmd_o(trq),
    .fe_reaction_o(frx), .err_log_o(elog));
  mwm_host host (.clk_i(clk), .obj_rdata_i(rdat), .obj_hit_i(hit), .obj_wr_o(wr), .obj_idx_o(idx),
    .obj_wdata_o(wd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the one-cycle pulse is counted mid-cycle, where it is settled
  always @(negedge clk) if (elog === 1'b1) n_log++;
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded watch of one status bit; a required bit that never comes ends the run
  task automatic till(input int b, input int n, input bit must, output logic g);
    g = 1'b0;
    for (int k = 0; k < n && !g; k++) begin
      @(negedge clk);
      g = status[b];
    end
    if (must && g !== 1'b1) begin
      n_mismatch++;
      $display("BAD wait status bit %0d exp %h got %h", b, 1'b1, g);
      complete_run();
    end
  endtask
  task automatic rc(input logic [15:0] i, input logic [31:0] e);
    host.rd(i, d, h);
    `CHK("rdata", e, d)
    `CHK("hit", 1'b1, h)
  endtask
  task automatic tq(input logic signed [7:0] m, input logic signed [15:0] t, input logic [15:0] l,
    input logic signed [15:0] e);
    host.wr(16'h6072, {16'h0000, l});
    host.wr(16'h6071, {{16{t[15]}}, t});
    mode = m;
    settle(3);
    `CHK("torque", e, trq)
  endtask
  initial begin
    rst = 1'b1;
    mode = 8'sh00;
    {pdem, pact, ptgt, vdem, vact} = '0;
    settle(6);
    rst = 1'b0;
    for (int k = 0; k < 11; k++) rc(ri[k], rv[k]);
    `CHK("status", 16'h0000, status)
    host.rd(16'h1234, d, h);
    `CHK("unmapped", 33'h000000000, {h, d})
    vdem = 32'sh80000001;
    vact = 32'shFFFFFF85;
    host.wr(16'h606B, 32'h12345678);
    host.wr(16'h606C, 32'h00000000);
    rc(16'h606B, 32'h80000001);
    rc(16'h606C, 32'hFFFFFF85);
    `CHK("vel_demand_o", 32'sh80000001, vdo)
    host.wr(16'h6066, 32'hABCD5555);
    rc(16'h6066, 32'h00005555);
    host.wr(16'h6071, 32'h0000FFF0);
    rc(16'h6071, 32'hFFFFFFF0);
    host.wr(16'h6072, 32'h0000FFFF);
    rc(16'h6072, 32'h0000FFFF);
    // following error: 2 ms limit, so three ticks outside are needed
    host.wr(16'h6066, 32'h00000002);
    host.wr(16'h6065, 32'h00000064);
    host.wr(16'h3700, 32'h00000005);
    pact = 32'sh000000C8;
    settle(18);
    `CHK("fe early", 1'b0, status[13])
    till(13, 60, 1'b1, got);
    settle(3);
    `CHK("fe bit", 1'b1, status[13])
    `CHK("reaction", 16'h0005, frx)
    `CHK("log count", 1, n_log)
    pact = 32'sh00000064;
    settle(3);
    `CHK("fe clear", 1'b0, status[13])
    `CHK("reaction off", 16'h0000, frx)
    host.wr(16'h6065, 32'hFFFFFFFF);
    pact = 32'sh00001388;
    till(13, 60, 1'b0, got);
    `CHK("fe off", 1'b0, got)
    // position window of 10 about a target of 1000
    host.wr(16'h6068, 32'h00000001);
    mode = 8'sh01;
    ptgt = 32'sh000003E8;
    {pdem, pact} = {2{32'sh000003ED}};
    till(10, 40, 1'b1, got);
    `CHK("pos hit", 1'b1, got)
    {pdem, pact} = {2{32'sh000003F2}};
    settle(3);
    `CHK("pos leave", 1'b0, status[10])
    till(10, 40, 1'b0, got);
    `CHK("pos edge", 1'b0, got)
    {pdem, pact} = {2{32'sh000003E3}};
    mode = 8'sh07;
    till(10, 40, 1'b1, got);
    `CHK("pos below", 1'b1, got)
    mode = 8'sh04;
    settle(3);
    till(10, 40, 1'b0, got);
    `CHK("pos mode", 1'b0, got)
    mode = 8'sh01;
    host.wr(16'h6067, 32'hFFFFFFFF);
    settle(3);
    till(10, 40, 1'b0, got);
    `CHK("pos off", 1'b0, got)
    // velocity window of 30 about a set speed of 500, zero time
    mode = 8'sh03;
    vdem = 32'sh000001F4;
    vact = 32'sh00000208;
    till(10, 40, 1'b1, got);
    `CHK("vel hit", 1'b1, got)
    vact = 32'sh000001D6;
    settle(3);
    till(10, 40, 1'b0, got);
    `CHK("vel edge", 1'b0, got)
    // following error again with no reaction set: flagged, but nothing logged
    host.wr(16'h3700, 32'h00000000);
    host.wr(16'h6065, 32'h00000064);
    pact = 32'sh00001388;
    till(13, 60, 1'b1, got);
    settle(2);
    `CHK("no log", 1, n_log)
    `CHK("no reaction", 16'h0000, frx)
    tq(8'sh04, 16'sh05DC, 16'h03E8, 16'sh03E8);
    tq(8'sh0A, -16'sh05DC, 16'h03E8, -16'sh03E8);
    tq(8'sh0A, 16'sh0FA0, 16'h1388, 16'sh0BB8);
    tq(8'sh04, 16'sh00C8, 16'h03E8, 16'sh00C8);
    tq(8'sh01, 16'sh00C8, 16'h03E8, 16'sh0000);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- tb/mwm_host.sv ----
// fieldbus host model driving the object read/write port
`timescale 1ns/1ps
`default_nettype none
module mwm_host (
  input wire logic clk_i,
  input wire logic [31:0] obj_rdata_i,
  input wire logic obj_hit_i,
  output logic obj_wr_o,
  output logic [15:0] obj_idx_o,
  output logic [31:0] obj_wdata_o
);
  initial begin
    obj_wr_o = 1'b0;
    obj_idx_o = 16'h0000;
    obj_wdata_o = 32'h00000000;
  end
  // the bench asks for torque above peak only to test the clamp
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(negedge clk_i);
    obj_wr_o = 1'b1;
    obj_idx_o = i;
    obj_wdata_o = d;
    @(negedge clk_i);
    obj_wr_o = 1'b0;
    // stale data is inverted so a late sample cannot pass by luck
    obj_wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] i, output logic [31:0] d, output logic h);
    @(negedge clk_i);
    obj_idx_o = i;
    @(negedge clk_i);
    d = obj_rdata_i;
    h = obj_hit_i;
  endtask
endmodule
`default_nettype wire
